/* File: bert_defines.svh */
`ifndef BERT_DEFINES_SVH
`define BERT_DEFINES_SVH

// register offsets on the multiplexed control port
`define PSET_GRP    6'h00
`define PLEN_OFS    8'h04
`define PTAP_OFS    8'h05
`define PCTRL_OFS   8'h06
`define EINS_OFS    8'h07
`define BITCNT_GRP  6'h02
`define ERRCNT_GRP  6'h03
`define RXCAP_GRP   6'h04

// pattern_control fields
`define PC_TLOAD    7
`define PC_ZSUP     6
`define PC_PSEL     5
`define PC_SNAP     4
`define PC_RCAP     3
`define PC_ARD      2
`define PC_RESYNC   1
`define PC_INTERNAL_LOOPBACK     0

// error_insert_control fields
`define EI_TINV     5
`define EI_RINV     4
`define EI_SBE      3

// reset values
`define PCTRL_RST   8'h00
`define EINS_RST    8'h00
`define PSET_RST    32'hffffffff
`define LEN_RST     5'h00
`define TAP_RST     5'h00

// strobe lanes toward the link section
`define ST_LOAD     0
`define ST_SNAP     1
`define ST_CAP      2
`define ST_RESYNC   3

// link section counts
`define ZERO_RUN    4'he
`define LOCK_RUN    6'h20
`define ERR_WIN     6'h3f
`define ERR_LIMIT   3'h6

// automatic error spacing in bits per rate code
`define GAP_1       24'h00000a
`define GAP_2       24'h000064
`define GAP_3       24'h0003e8
`define GAP_4       24'h002710
`define GAP_5       24'h0186a0
`define GAP_6       24'h0f4240
`define GAP_7       24'h989680

`endif

/* File: bert_pkg.sv */
package bert_pkg;

    typedef struct packed {
        logic [31:0] pattern_set;
        logic [4:0]  length;
        logic [4:0]  tap;
        logic [7:0]  pattern_control;
        logic [7:0]  error_insert_control;
    } cfg_s;

    typedef struct packed {
        logic [31:0] bit_count_snapshot;
        logic [31:0] error_count_snapshot;
        logic [31:0] rx_pattern_capture;
    } result_s;

    typedef enum logic {DET_HUNT, DET_LOCKED} det_e;

    typedef struct packed {
        logic        rst_s1;
        logic        rst_s2;
        logic        cfg_tog_s1;
        logic        cfg_tog_s2;
        logic        cfg_tog_s3;
        cfg_s        cfg;
        logic [3:0]  str_s1;
        logic [3:0]  str_s2;
        logic [3:0]  str_prev;
        logic        rdata_s1;
        logic        rdata_s2;
        logic [31:0] gen;
        logic        tdata;
        logic [3:0]  zrun;
        logic [23:0] gap;
        logic        sbe_prev;
        logic        sbe_pend;
        det_e        det;
        logic [31:0] ref_pat;
        logic [31:0] hist;
        logic [5:0]  run;
        logic [5:0]  win;
        logic [2:0]  werr;
        logic [31:0] bitc;
        logic [31:0] errc;
        result_s     res;
        logic        res_tog;
    } link_s;

    typedef struct packed {
        logic        ale_s1;
        logic        ale_s2;
        logic        ale_prev;
        logic        rd_n_s1;
        logic        rd_n_s2;
        logic        wr_n_s1;
        logic        wr_n_s2;
        logic        wr_n_prev;
        logic        cs_n_s1;
        logic        cs_n_s2;
        logic [7:0]  ad_s1;
        logic [7:0]  ad_s2;
        logic [2:0]  pin_s1;
        logic [2:0]  pin_s2;
        logic [7:0]  addr;
        cfg_s        cfg;
        logic        cfg_tog;
        logic [3:0]  str_lvl;
        logic        res_tog_s1;
        logic        res_tog_s2;
        logic        res_tog_s3;
        result_s     res;
        logic [7:0]  ad_out;
        logic        ad_oe;
    } top_s;

endpackage

/* File: bert_link_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bert_defines.svh"

module bert_link_engine (
    input  wire logic             link_clk,  // serial bit clock
    input  wire logic             sys_rst,   // reset from control domain
    input  wire bert_pkg::cfg_s   cfg_in,    // held settings
    input  wire logic             cfg_tog,   // flips on each write
    input  wire logic [3:0]       str_lvl,   // combined strobe levels
    input  wire logic             rdata,     // serial input pin
    output logic                  tdata,     // serial output
    output bert_pkg::result_s     res,       // held snapshot words
    output logic                  res_tog    // flips on each snapshot or capture
);
    bert_pkg::link_s s_reg;
    bert_pkg::link_s s_next;
    logic [3:0]  edge_hit;
    logic        sbe_edge;
    logic        gen_bit;
    logic        rx_bit;
    logic        pred;
    logic        match;

    function automatic logic [23:0] gap_of(input logic [2:0] code);
        case (code)
            3'h1: gap_of = `GAP_1;
            3'h2: gap_of = `GAP_2;
            3'h3: gap_of = `GAP_3;
            3'h4: gap_of = `GAP_4;
            3'h5: gap_of = `GAP_5;
            3'h6: gap_of = `GAP_6;
            3'h7: gap_of = `GAP_7;
            default: gap_of = 24'h000000;
        endcase
    endfunction

    assign edge_hit = s_reg.str_s2 & ~s_reg.str_prev;
    assign sbe_edge = s_reg.cfg.error_insert_control[`EI_SBE]
                      & ~s_reg.sbe_prev;
    assign tdata    = s_reg.tdata;
    assign res      = s_reg.res;
    assign res_tog  = s_reg.res_tog;

    always_comb begin
        s_next = s_reg;
        s_next.rst_s1     = sys_rst;
        s_next.rst_s2     = s_reg.rst_s1;
        s_next.cfg_tog_s1 = cfg_tog;
        s_next.cfg_tog_s2 = s_reg.cfg_tog_s1;
        s_next.cfg_tog_s3 = s_reg.cfg_tog_s2;
        s_next.str_s1     = str_lvl;
        s_next.str_s2     = s_reg.str_s1;
        s_next.str_prev   = s_reg.str_s2;
        s_next.rdata_s1   = rdata;
        s_next.rdata_s2   = s_reg.rdata_s1;
        s_next.sbe_prev   = s_reg.cfg.error_insert_control[`EI_SBE];
        // settings are stable by the time the toggle lands here
        if (s_reg.cfg_tog_s2 != s_reg.cfg_tog_s3) begin
            s_next.cfg = cfg_in;
        end

        // generator: one tap pair serves both pattern kinds
        gen_bit = s_reg.gen[s_reg.cfg.length];
        if (s_reg.cfg.pattern_control[`PC_ZSUP]
            && s_reg.zrun == `ZERO_RUN) begin
            gen_bit = 1'b1;
        end
        s_next.gen = {s_reg.gen[30:0],
                      s_reg.gen[s_reg.cfg.length]
                      ^ (s_reg.cfg.pattern_control[`PC_PSEL]
                         & s_reg.gen[s_reg.cfg.tap])};
        s_next.zrun = gen_bit ? 4'h0
                    : (s_reg.zrun == `ZERO_RUN ? s_reg.zrun
                       : s_reg.zrun + 4'h1);
        if (s_reg.cfg.error_insert_control[2:0] == 3'h0) begin
            s_next.gap = 24'h000000;
        end else if (s_reg.gap + 24'h000001
                     >= gap_of(s_reg.cfg.error_insert_control[2:0])) begin
            s_next.gap = 24'h000000;
        end else begin
            s_next.gap = s_reg.gap + 24'h000001;
        end
        s_next.tdata = gen_bit
            ^ s_reg.sbe_pend
            ^ (s_next.gap == 24'h000000
               && s_reg.cfg.error_insert_control[2:0] != 3'h0)
            ^ s_reg.cfg.error_insert_control[`EI_TINV];
        s_next.sbe_pend = sbe_edge;
        if (edge_hit[`ST_LOAD]) begin
            s_next.gen  = s_reg.cfg.pattern_set;
            s_next.zrun = 4'h0;
        end

        // detector: self-seeds while hunting, free-runs once locked
        rx_bit = (s_reg.cfg.pattern_control[`PC_INTERNAL_LOOPBACK] ? s_reg.tdata
                  : s_reg.rdata_s2)
                 ^ s_reg.cfg.error_insert_control[`EI_RINV];
        pred = s_reg.ref_pat[s_reg.cfg.length]
               ^ (s_reg.cfg.pattern_control[`PC_PSEL]
                  & s_reg.ref_pat[s_reg.cfg.tap]);
        match = (rx_bit == pred);
        s_next.hist = {s_reg.hist[30:0], rx_bit};
        s_next.ref_pat = {s_reg.ref_pat[30:0],
                          s_reg.det == bert_pkg::DET_HUNT ? rx_bit : pred};
        case (s_reg.det)
            bert_pkg::DET_HUNT: begin
                s_next.run = match ? s_reg.run + 6'h01 : 6'h00;
                if (match && s_reg.run == `LOCK_RUN - 6'h01) begin
                    s_next.det  = bert_pkg::DET_LOCKED;
                    s_next.win  = 6'h00;
                    s_next.werr = 3'h0;
                end
            end
            bert_pkg::DET_LOCKED: begin
                s_next.bitc = s_reg.bitc + 32'h00000001;
                s_next.errc = s_reg.errc + {31'h0, !match};
                s_next.win  = s_reg.win + 6'h01;
                if (!match && s_reg.werr != `ERR_LIMIT) begin
                    s_next.werr = s_reg.werr + 3'h1;
                end
                if (s_reg.win == `ERR_WIN) begin
                    s_next.werr = 3'h0;
                end
                if (s_reg.werr == `ERR_LIMIT
                    && !s_reg.cfg.pattern_control[`PC_ARD]) begin
                    s_next.det = bert_pkg::DET_HUNT;
                    s_next.run = 6'h00;
                end
            end
            default: s_next.det = bert_pkg::DET_HUNT;
        endcase
        if (edge_hit[`ST_RESYNC]) begin
            s_next.det = bert_pkg::DET_HUNT;
            s_next.run = 6'h00;
        end
        if (edge_hit[`ST_SNAP]) begin
            s_next.res.bit_count_snapshot   = s_reg.bitc;
            s_next.res.error_count_snapshot = s_reg.errc;
            s_next.bitc    = 32'h00000000;
            s_next.errc    = 32'h00000000;
            s_next.res_tog = ~s_reg.res_tog;
        end
        if (edge_hit[`ST_CAP]) begin
            s_next.res.rx_pattern_capture = s_reg.hist;
            s_next.res_tog = ~s_reg.res_tog;
        end

        if (s_reg.rst_s2) begin
            s_next          = '0;
            s_next.rst_s1   = sys_rst;
            s_next.rst_s2   = s_reg.rst_s1;
            s_next.cfg      = cfg_in;
            s_next.str_s1   = str_lvl;
            s_next.rdata_s1 = rdata;
            s_next.det      = bert_pkg::DET_HUNT;
        end
    end

    always_ff @(posedge link_clk) begin
        s_reg <= s_next;
    end

    gen_load_a: assert property (@(posedge link_clk)
        disable iff (s_reg.rst_s2)
        edge_hit[`ST_LOAD] |=> s_reg.gen == $past(s_reg.cfg.pattern_set))
        else $error("generator not loaded on load edge");
    zero_cap_a: assert property (@(posedge link_clk)
        disable iff (s_reg.rst_s2)
        s_reg.cfg.pattern_control[`PC_ZSUP] && s_reg.zrun == `ZERO_RUN
        |=> s_reg.zrun == 4'h0)
        else $error("zero run exceeded limit");
    snap_clear_a: assert property (@(posedge link_clk)
        disable iff (s_reg.rst_s2)
        edge_hit[`ST_SNAP] |=> s_reg.bitc == 32'h0 && s_reg.errc == 32'h0
        && s_reg.res.bit_count_snapshot == $past(s_reg.bitc))
        else $error("count snapshot wrong");
    rx_capture_a: assert property (@(posedge link_clk)
        disable iff (s_reg.rst_s2)
        edge_hit[`ST_CAP] |=> s_reg.res.rx_pattern_capture
        == $past(s_reg.hist))
        else $error("receive capture wrong");
    hold_lock_a: assert property (@(posedge link_clk)
        disable iff (s_reg.rst_s2)
        s_reg.det == bert_pkg::DET_LOCKED
        && s_reg.cfg.pattern_control[`PC_ARD] && !edge_hit[`ST_RESYNC]
        |=> s_reg.det == bert_pkg::DET_LOCKED)
        else $error("auto resync while disabled");
    resync_hunt_a: assert property (@(posedge link_clk)
        disable iff (s_reg.rst_s2)
        edge_hit[`ST_RESYNC] |=> s_reg.det == bert_pkg::DET_HUNT)
        else $error("manual resync ignored");
    single_err_a: assert property (@(posedge link_clk)
        disable iff (s_reg.rst_s2)
        sbe_edge |=> s_reg.sbe_pend ##1 !s_reg.sbe_pend)
        else $error("single error not one bit");
    loop_path_a: assert property (@(posedge link_clk)
        disable iff (s_reg.rst_s2)
        s_reg.cfg.pattern_control[`PC_INTERNAL_LOOPBACK]
        && !s_reg.cfg.error_insert_control[`EI_RINV]
        |=> s_reg.hist[0] == $past(s_reg.tdata))
        else $error("loopback path not taken");
endmodule
`default_nettype wire

/* File: bert_pattern_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bert_defines.svh"

// Operation
// - Rising load strobe, bit or pin, loads generator from pattern set.
// - Zero suppression forces a one after fourteen zeros in a row.
// - Pattern select picks repetitive (0) or pseudorandom (1) sequence.
// - Rising snapshot strobe copies bit and error counts, then clears them.
// - Snapshot bit is ORed with its pin; host clears before re-setting.
// - Rising capture strobe stores last 32 received bits.
// - Capture bit is ORed with its pin; host clears before re-setting.
// - Auto realign disable bit stops automatic re-acquisition of lock.
// - Rising manual resync strobe restarts detector synchronisation.
// - Errors are inserted at regular intervals per the rate code.
// - Single error bit inserts one error on demand.
// - Rate code zero disables; codes one to seven give 1e-1 to 1e-7.
// - Each single error rising edge corrupts exactly one bit; on the bit of an automatic error the two cancel.
module bert_pattern_control (
    input  wire logic       CLK,                    // control clock
    input  wire logic       SYS_RST,                // sync reset, high
    input  wire logic       LINK_CLK,               // serial bit clock
    input  wire logic       ALE,                    // address latch enable
    input  wire logic       CS_N,                   // chip select, low
    input  wire logic       RD_N,                   // read strobe, low
    input  wire logic       WR_N,                   // write strobe, low
    input  wire logic [7:0] AD_IN,                  // bus pins in
    output logic      [7:0] AD_OUT,                 // bus pins out
    output logic            AD_OE,                  // bus pins driven
    input  wire logic       TRANSMIT_LOAD_STROBE,   // load pin
    input  wire logic       COUNT_SNAPSHOT_STROBE,  // snapshot pin
    input  wire logic       RECEIVE_CAPTURE_STROBE, // capture pin
    input  wire logic       RX_DATA,                // serial input
    output logic            TX_DATA                 // serial output
);
    bert_pkg::top_s    s_reg;
    bert_pkg::top_s    s_next;
    bert_pkg::result_s link_res;
    logic              link_res_tog;
    logic              ale_fall;
    logic              wr_rise;
    logic              rd_act;

    function automatic logic [7:0] byte_of(input logic [31:0] w,
                                           input logic [1:0]  i);
        case (i)
            2'h0:    byte_of = w[31:24];
            2'h1:    byte_of = w[23:16];
            2'h2:    byte_of = w[15:8];
            default: byte_of = w[7:0];
        endcase
    endfunction

    assign ale_fall = s_reg.ale_prev & ~s_reg.ale_s2;
    assign wr_rise  = ~s_reg.wr_n_prev & s_reg.wr_n_s2 & ~s_reg.cs_n_s2;
    assign rd_act   = ~s_reg.rd_n_s2 & ~s_reg.cs_n_s2;
    assign AD_OUT   = s_reg.ad_out;
    assign AD_OE    = s_reg.ad_oe;

    always_comb begin
        s_next = s_reg;
        // every bus and strobe pin is two flops deep before use
        s_next.ale_s1    = ALE;
        s_next.ale_s2    = s_reg.ale_s1;
        s_next.ale_prev  = s_reg.ale_s2;
        s_next.rd_n_s1   = RD_N;
        s_next.rd_n_s2   = s_reg.rd_n_s1;
        s_next.wr_n_s1   = WR_N;
        s_next.wr_n_s2   = s_reg.wr_n_s1;
        s_next.wr_n_prev = s_reg.wr_n_s2;
        s_next.cs_n_s1   = CS_N;
        s_next.cs_n_s2   = s_reg.cs_n_s1;
        s_next.ad_s1     = AD_IN;
        s_next.ad_s2     = s_reg.ad_s1;
        s_next.pin_s1    = {RECEIVE_CAPTURE_STROBE,
                            COUNT_SNAPSHOT_STROBE,
                            TRANSMIT_LOAD_STROBE};
        s_next.pin_s2    = s_reg.pin_s1;

        if (ale_fall) begin
            s_next.addr = s_reg.ad_s2;
        end

        // write data is taken as the strobe ends, when it is surely stable
        if (wr_rise) begin
            s_next.cfg_tog = ~s_reg.cfg_tog;
            if (s_reg.addr[7:2] == `PSET_GRP) begin
                case (s_reg.addr[1:0])
                    2'h0: s_next.cfg.pattern_set[31:24] = s_reg.ad_s2;
                    2'h1: s_next.cfg.pattern_set[23:16] = s_reg.ad_s2;
                    2'h2: s_next.cfg.pattern_set[15:8]  = s_reg.ad_s2;
                    default: s_next.cfg.pattern_set[7:0] = s_reg.ad_s2;
                endcase
            end
            case (s_reg.addr)
                `PLEN_OFS:  s_next.cfg.length = s_reg.ad_s2[4:0];
                `PTAP_OFS:  s_next.cfg.tap    = s_reg.ad_s2[4:0];
                `PCTRL_OFS: s_next.cfg.pattern_control = s_reg.ad_s2;
                `EINS_OFS:  s_next.cfg.error_insert_control = s_reg.ad_s2;
                default:    s_next.cfg = s_next.cfg;
            endcase
        end

        // bit ORed with pin where there is one, carried as a level; edges found on link side
        s_next.str_lvl[`ST_LOAD] =
            s_reg.cfg.pattern_control[`PC_TLOAD] | s_reg.pin_s2[0];
        s_next.str_lvl[`ST_SNAP] =
            s_reg.cfg.pattern_control[`PC_SNAP] | s_reg.pin_s2[1];
        s_next.str_lvl[`ST_CAP] =
            s_reg.cfg.pattern_control[`PC_RCAP] | s_reg.pin_s2[2];
        s_next.str_lvl[`ST_RESYNC] =
            s_reg.cfg.pattern_control[`PC_RESYNC];

        // link results are held still until the toggle has crossed
        s_next.res_tog_s1 = link_res_tog;
        s_next.res_tog_s2 = s_reg.res_tog_s1;
        s_next.res_tog_s3 = s_reg.res_tog_s2;
        if (s_reg.res_tog_s2 != s_reg.res_tog_s3) begin
            s_next.res = link_res;
        end

        s_next.ad_oe  = rd_act;
        s_next.ad_out = 8'h00;
        if (rd_act) begin
            case (s_reg.addr[7:2])
                `PSET_GRP:
                    s_next.ad_out = byte_of(s_reg.cfg.pattern_set,
                                            s_reg.addr[1:0]);
                `BITCNT_GRP:
                    s_next.ad_out = byte_of(s_reg.res.bit_count_snapshot,
                                            s_reg.addr[1:0]);
                `ERRCNT_GRP:
                    s_next.ad_out = byte_of(s_reg.res.error_count_snapshot,
                                            s_reg.addr[1:0]);
                `RXCAP_GRP:
                    s_next.ad_out = byte_of(s_reg.res.rx_pattern_capture,
                                            s_reg.addr[1:0]);
                default:
                    s_next.ad_out = 8'h00;
            endcase
            case (s_reg.addr)
                `PLEN_OFS:  s_next.ad_out = {3'h0, s_reg.cfg.length};
                `PTAP_OFS:  s_next.ad_out = {3'h0, s_reg.cfg.tap};
                `PCTRL_OFS: s_next.ad_out = s_reg.cfg.pattern_control;
                `EINS_OFS:  s_next.ad_out = s_reg.cfg.error_insert_control;
                default:    s_next.ad_out = s_next.ad_out;
            endcase
        end

        if (SYS_RST) begin
            s_next = '0;
            s_next.ale_s1    = ALE;
            s_next.rd_n_s1   = RD_N;
            s_next.rd_n_s2   = 1'b1;
            s_next.wr_n_s1   = WR_N;
            s_next.wr_n_s2   = 1'b1;
            s_next.wr_n_prev = 1'b1;
            s_next.cs_n_s1   = CS_N;
            s_next.cs_n_s2   = 1'b1;
            s_next.res_tog_s1 = link_res_tog;
            s_next.cfg.pattern_set          = `PSET_RST;
            s_next.cfg.length               = `LEN_RST;
            s_next.cfg.tap                  = `TAP_RST;
            s_next.cfg.pattern_control      = `PCTRL_RST;
            s_next.cfg.error_insert_control = `EINS_RST;
        end
    end

    always_ff @(posedge CLK) begin
        s_reg <= s_next;
    end

    bert_link_engine u_link (
        .link_clk (LINK_CLK),
        .sys_rst  (SYS_RST),
        .cfg_in   (s_reg.cfg),
        .cfg_tog  (s_reg.cfg_tog),
        .str_lvl  (s_reg.str_lvl),
        .rdata    (RX_DATA),
        .tdata    (TX_DATA),
        .res      (link_res),
        .res_tog  (link_res_tog)
    );

    addr_latch_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ale_fall |=> s_reg.addr == $past(s_reg.ad_s2))
        else $error("address not latched on latch fall");
    ctrl_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_rise && s_reg.addr == `PCTRL_OFS
        |=> s_reg.cfg.pattern_control == $past(s_reg.ad_s2)
            && s_reg.cfg_tog != $past(s_reg.cfg_tog))
        else $error("pattern control write lost");
    ctrl_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        rd_act && s_reg.addr == `PCTRL_OFS
        |=> AD_OE && AD_OUT == $past(s_reg.cfg.pattern_control))
        else $error("pattern control readback wrong");
    load_or_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> s_reg.str_lvl[`ST_LOAD]
        == ($past(s_reg.cfg.pattern_control[`PC_TLOAD])
            | $past(s_reg.pin_s2[0])))
        else $error("load strobe not bit or pin");
    snap_or_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> s_reg.str_lvl[`ST_SNAP]
        == ($past(s_reg.cfg.pattern_control[`PC_SNAP])
            | $past(s_reg.pin_s2[1])))
        else $error("snapshot strobe not bit or pin");
    cap_or_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> s_reg.str_lvl[`ST_CAP]
        == ($past(s_reg.cfg.pattern_control[`PC_RCAP])
            | $past(s_reg.pin_s2[2])))
        else $error("capture strobe not bit or pin");
    result_take_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_reg.res_tog_s2 != s_reg.res_tog_s3
        |=> s_reg.res == $past(link_res))
        else $error("link result not taken");
    read_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !rd_act |=> !AD_OE && AD_OUT == 8'h00)
        else $error("bus driven outside a read");
    resync_lvl_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !$past(SYS_RST) |-> s_reg.str_lvl[`ST_RESYNC]
        == $past(s_reg.cfg.pattern_control[`PC_RESYNC]))
        else $error("resync strobe not from its bit");
    len_write_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        wr_rise && s_reg.addr == `PLEN_OFS
        |=> s_reg.cfg.length == $past(s_reg.ad_s2[4:0]))
        else $error("length write lost");
endmodule
`default_nettype wire

/* File: bert_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module bert_link_partner (
    input  wire logic link_clk, // bit clock
    input  wire logic tx,       // stream from tester
    output logic      rx        // stream back to tester
);
    // loop back half a bit late, away from the sampling edge
    initial rx = 1'b0;
    always @(negedge link_clk) begin
        rx <= tx;
    end
endmodule
`default_nettype wire

/* File: bert_pattern_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module bert_pattern_control_bench;
    logic        clk, sys_rst, link_clk, ale, cs_n, rd_n, wr_n;
    logic [7:0]  ad_drv, ad_out, b;
    logic        ad_oe, tls, css, rcs, rx, tx;
    logic [31:0] w, r;
    logic [7:0]  adr [4] = '{8'h04, 8'h05, 8'h06, 8'h1c};
    int          n_errors, num_checks;
    wire  [7:0]  ad = ad_oe ? ad_out : ad_drv;

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = ~link_clk;
    end

    bert_pattern_control i_bert_pattern_control (.CLK(clk),
        .SYS_RST(sys_rst), .LINK_CLK(link_clk), .ALE(ale), .CS_N(cs_n),
        .RD_N(rd_n), .WR_N(wr_n), .AD_IN(ad), .AD_OUT(ad_out),
        .AD_OE(ad_oe), .TRANSMIT_LOAD_STROBE(tls),
        .COUNT_SNAPSHOT_STROBE(css), .RECEIVE_CAPTURE_STROBE(rcs),
        .RX_DATA(rx), .TX_DATA(tx));
    bert_link_partner i_bert_link_partner (.link_clk(link_clk), .tx(tx),
        .rx(rx));

    function automatic logic [7:0] exp_rb(logic [7:0] a, logic [7:0] d);
        if (a == 8'h04 || a == 8'h05)
            return d & 8'h1f;
        return (a == 8'h06) ? d : 8'h00;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic addr(input logic [7:0] a);
        ale = 1'b1;
        ad_drv = a;
        cyc(4);
        ale = 1'b0;
        cyc(4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr(a);
        cs_n = 1'b0;
        wr_n = 1'b0;
        ad_drv = d;
        cyc(4);
        wr_n = 1'b1;
        // select stays low past the strobe rise, which is where data lands
        cyc(3);
        cs_n = 1'b1;
        cyc(9);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr(a);
        cs_n = 1'b0;
        rd_n = 1'b0;
        cyc(5);
        chk(32'(ad_oe), 32'h1);
        d = ad_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
        cyc(5);
    endtask
    task automatic rd32(input logic [7:0] a, output logic [31:0] v);
        logic [7:0] x;
        for (int i = 0; i < 4; i++) begin
            rd(a + 8'(i), x);
            v = {v[23:0], x};
        end
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        void'($urandom(32'hd180de2f));
        {sys_rst, ale, cs_n, rd_n, wr_n, tls, css, rcs} = 8'hb8;
        ad_drv = 8'h00;
        cyc(8);
        sys_rst = 1'b0;
        cyc(8);
        rd32(8'h00, r);
        chk(r, 32'hffffffff);
        rd(8'h06, b);
        chk(32'(b), 32'h0);
        foreach (adr[i]) begin
            // strobe bits kept low so no action fires here
            w = $urandom & ((adr[i] == 8'h06) ? 32'h65 : 32'hff);
            wr(adr[i], w[7:0]);
            rd(adr[i], b);
            chk(32'(b), 32'(exp_rb(adr[i], w[7:0])));
        end
        wr(8'h04, 8'h00);
        wr(8'h06, 8'h00);
        tls = 1'b1;
        cyc(10);
        tls = 1'b0;
        wr(8'h06, 8'h02);
        wr(8'h06, 8'h00);
        cyc(150);
        css = 1'b1;
        cyc(10);
        css = 1'b0;
        cyc(10);
        wr(8'h07, 8'h08);
        cyc(100);
        wr(8'h07, 8'h00);
        cyc(60);
        wr(8'h06, 8'h10);
        wr(8'h06, 8'h00);
        rd32(8'h0c, r);
        chk(r, 32'h1);
        rcs = 1'b1;
        cyc(10);
        rcs = 1'b0;
        cyc(10);
        rd32(8'h10, r);
        chk(r, 32'hffffffff);
        wr(8'h04, 8'h06);
        wr(8'h05, 8'h00);
        wr(8'h07, 8'h02);
        wr(8'h06, 8'ha1);
        wr(8'h06, 8'h23);
        wr(8'h06, 8'h21);
        cyc(200);
        wr(8'h06, 8'h31);
        wr(8'h06, 8'h21);
        cyc(600);
        wr(8'h06, 8'h31);
        // one error per 100 bits over 432 locked bit times
        rd32(8'h0c, r);
        chk(32'(r == 32'h4 || r == 32'h5), 32'h1);
        rd32(8'h08, r);
        chk(32'(r >= 32'h1ac && r <= 32'h1b4), 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
